// file: audio_serial_pkg.sv
// Shared formats, widths and timing figures of the serial audio input link.
// Used by both ends and by the checker; nothing here is synthesised alone.
package audio_serial_pkg;

    // ==========================================================
    // Formats and word widths
    typedef enum logic [1:0] {
        FMT_LEFT_JUST,
        FMT_I2S,
        FMT_RIGHT_JUST
    } format_t;

    typedef enum logic [1:0] {
        WIDTH_16,
        WIDTH_18,
        WIDTH_20,
        WIDTH_24
    } width_t;

    localparam format_t DEFAULT_FORMAT = FMT_I2S;
    localparam width_t DEFAULT_WIDTH = WIDTH_24;
    localparam int MAX_BITS = 24;
    localparam int SLOT_BITS = 32;
    localparam int CNT_BITS = 6;

    // ==========================================================
    // Frame-sync to MSB delays in bit-clock periods
    localparam logic [5:0] DELAY_LJ = 6'h00;
    localparam logic [5:0] DELAY_I2S = 6'h01;
    localparam logic [5:0] DELAY_RJ16 = 6'h10;
    localparam logic [5:0] DELAY_RJ18 = 6'h0E;
    localparam logic [5:0] DELAY_RJ20 = 6'h0C;
    localparam logic [5:0] DELAY_RJ24 = 6'h08;

    // ==========================================================
    // Bit clock made by the source: half period in system clocks
    localparam int SYS_CLK_NS = 100;
    localparam int BIT_CLK_MIN_NS = 80;
    localparam int HALF_DIV = (BIT_CLK_MIN_NS + 2 * SYS_CLK_NS - 1)
        / (2 * SYS_CLK_NS);

    function automatic logic [4:0] word_bits(input width_t w);
        unique case (w)
            WIDTH_16: word_bits = 5'h10;
            WIDTH_18: word_bits = 5'h12;
            WIDTH_20: word_bits = 5'h14;
            WIDTH_24: word_bits = 5'h18;
        endcase
    endfunction

    // Bit-clock periods from frame-sync edge to MSB
    function automatic logic [5:0] msb_delay(input format_t f,
                                             input width_t w);
        if (f == FMT_LEFT_JUST) begin
            msb_delay = DELAY_LJ;
        end else if (f == FMT_I2S) begin
            msb_delay = DELAY_I2S;
        end else begin
            unique case (w)
                WIDTH_16: msb_delay = DELAY_RJ16;
                WIDTH_18: msb_delay = DELAY_RJ18;
                WIDTH_20: msb_delay = DELAY_RJ20;
                WIDTH_24: msb_delay = DELAY_RJ24;
            endcase
        end
    endfunction

    // Frame-sync level that marks the left channel
    function automatic logic left_level(input format_t f);
        left_level = (f != FMT_I2S);
    endfunction

endpackage

// file: audio_serial_if.sv
// Three-wire serial audio link: bit clock, frame sync and data.
// The source drives all three; the transmitter input only listens.
`timescale 1ns/1ps
interface audio_serial_if;
    logic bitClk;
    logic frameSync;
    logic serialData;

    modport source (
        output bitClk,
        output frameSync,
        output serialData
    );

    modport sink (
        input bitClk,
        input frameSync,
        input serialData
    );
endinterface

// file: spdif_tx_serial_input.sv
// Transmitter serial input: deserialises left/right words from the link.
// Link logic runs on the incoming bit clock; stereo pairs cross to sys_clk
// by a toggle handshake with the pair held stable in the link domain.
// Link-domain reset is released by the bit clock itself.
`timescale 1ns/1ps

// Operation
// - Three formats, widths 16, 18, 20, 24
// - Data sampled on rising bit-clock edge
// - Right justified: sync high is left
// - Right justified MSB delay 16/14/12/8
// - Right justified LSB ends before sync edge
// - I2S is the format after reset
// - I2S: sync low is left
// - I2S MSB one period after sync edge
// - Left justified: sync high left, no delay
module spdif_tx_serial_input #(
    parameter int WORD_MAX = audio_serial_pkg::MAX_BITS
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire audio_serial_pkg::format_t formatSel,
    input wire audio_serial_pkg::width_t widthSel,
    audio_serial_if.sink link,
    output logic [WORD_MAX-1:0] leftSample,
    output logic [WORD_MAX-1:0] rightSample,
    output logic sampleValid,
    output audio_serial_pkg::format_t activeFormat
);

    // ==========================================================
    // Configuration, caught in the system domain
    audio_serial_pkg::format_t cfgFormat;
    audio_serial_pkg::width_t cfgWidth;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfgFormat <= audio_serial_pkg::DEFAULT_FORMAT;
            cfgWidth <= audio_serial_pkg::DEFAULT_WIDTH;
        end else begin
            cfgFormat <= formatSel;
            cfgWidth <= widthSel;
        end
    end

    // ==========================================================
    // Link-domain reset: asserted at once, released on the bit clock
    // Release must not race a bit-clock edge, hence two stages
    logic rstMeta_n;
    logic linkRst_n;
    always_ff @(posedge link.bitClk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_n <= 1'b0;
            linkRst_n <= 1'b0;
        end else begin
            rstMeta_n <= 1'b1;
            linkRst_n <= rstMeta_n;
        end
    end

    // Config is quasi-static: change it only while the link is idle
    logic [3:0] cfgMeta;
    logic [3:0] cfgLink;
    always_ff @(posedge link.bitClk or negedge linkRst_n) begin
        if (!linkRst_n) begin
            cfgMeta <= {audio_serial_pkg::DEFAULT_FORMAT,
                        audio_serial_pkg::DEFAULT_WIDTH};
            cfgLink <= {audio_serial_pkg::DEFAULT_FORMAT,
                        audio_serial_pkg::DEFAULT_WIDTH};
        end else begin
            cfgMeta <= {cfgFormat, cfgWidth};
            cfgLink <= cfgMeta;
        end
    end

    wire audio_serial_pkg::format_t linkFormat =
        audio_serial_pkg::format_t'(cfgLink[3:2]);
    wire audio_serial_pkg::width_t linkWidth =
        audio_serial_pkg::width_t'(cfgLink[1:0]);
    wire [5:0] msbDelay = audio_serial_pkg::msb_delay(linkFormat, linkWidth);
    wire [4:0] wordBits = audio_serial_pkg::word_bits(linkWidth);

    // ==========================================================
    // Link domain: slot counter and shifter
    logic syncPrev;
    logic [5:0] bitCount;
    logic [WORD_MAX-1:0] shiftWord;
    logic [WORD_MAX-1:0] heldLeft;
    logic [WORD_MAX-1:0] pairLeft;
    logic [WORD_MAX-1:0] pairRight;
    logic haveLeft;
    logic pairToggle;

    // Both sampled at the rising edge, in step with each other
    wire syncEdge = link.frameSync != syncPrev;
    wire [5:0] pos = syncEdge ? 6'h00 : bitCount;
    wire leftLevel = audio_serial_pkg::left_level(linkFormat);
    // syncPrev still holds the level of the slot that just ended
    wire isLeft = syncPrev == leftLevel;
    // Slot ends at the sync edge; in right justified the LSB lands just before it
    wire slotDone = syncEdge;
    wire atMsb = pos >= msbDelay;
    wire [5:0] rel = pos - msbDelay;
    // Bits past the word width fall outside the word and are not shifted
    wire inWord = atMsb && (rel < {1'b0, wordBits});
    // Counter saturates so a missing sync edge cannot wrap it into a word
    wire [5:0] nextCount = (bitCount == 6'h3F) ? bitCount : bitCount + 6'h01;
    wire [5:0] next_bitCount = syncEdge ? 6'h01 : nextCount;

    // A right word with no left word before it is dropped
    wire takeLeft = slotDone && isLeft;
    wire takePair = slotDone && !isLeft && haveLeft;
    // A new slot starts from zero so a short word has clean upper bits
    wire [WORD_MAX-1:0] baseWord = syncEdge ? '0 : shiftWord;
    wire [WORD_MAX-1:0] next_shiftWord = inWord ?
        {baseWord[WORD_MAX-2:0], link.serialData} : baseWord;

    always_ff @(posedge link.bitClk or negedge linkRst_n) begin
        if (!linkRst_n) begin
            syncPrev <= 1'b0;
            bitCount <= 6'h00;
            shiftWord <= '0;
        end else begin
            syncPrev <= link.frameSync;
            bitCount <= next_bitCount;
            shiftWord <= next_shiftWord;
        end
    end

    always_ff @(posedge link.bitClk or negedge linkRst_n) begin
        if (!linkRst_n) begin
            heldLeft <= '0;
            haveLeft <= 1'b0;
        end else if (takeLeft) begin
            heldLeft <= shiftWord;
            haveLeft <= 1'b1;
        end else if (takePair) begin
            haveLeft <= 1'b0;
        end
    end

    always_ff @(posedge link.bitClk or negedge linkRst_n) begin
        if (!linkRst_n) begin
            pairLeft <= '0;
            pairRight <= '0;
            pairToggle <= 1'b0;
        end else if (takePair) begin
            pairLeft <= heldLeft;
            pairRight <= shiftWord;
            pairToggle <= ~pairToggle;
        end
    end

    // ==========================================================
    // Pair crossing into the system domain
    // Toggle, not pulse: a one-bit-clock pulse could fall between
    // two system clocks when the link runs faster than the system
    logic toggleMeta;
    logic toggleSync;
    logic toggleSeen;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            toggleMeta <= 1'b0;
            toggleSync <= 1'b0;
            toggleSeen <= 1'b0;
        end else begin
            toggleMeta <= pairToggle;
            toggleSync <= toggleMeta;
            toggleSeen <= toggleSync;
        end
    end

    // Pair registers hold for a whole frame, far longer than the sync delay
    wire pairArrived = toggleSeen != toggleSync;

    // Reports the format caught in the system domain, which the link copy follows later
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            activeFormat <= audio_serial_pkg::DEFAULT_FORMAT;
        end else begin
            activeFormat <= cfgFormat;
        end
    end

    // One pulse per pair; the next pair is a frame away
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sampleValid <= 1'b0;
        end else begin
            sampleValid <= pairArrived;
        end
    end

    // Samples only move with the strobe, so they hold between pairs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            leftSample <= '0;
            rightSample <= '0;
        end else if (pairArrived) begin
            leftSample <= pairLeft;
            rightSample <= pairRight;
        end
    end

endmodule

// file: audio_serial_source.sv
// Serial audio source: makes the bit clock by dividing sys_clk and sends
// one stereo pair per 64-period frame in the chosen format.
`timescale 1ns/1ps
module audio_serial_source #(
    parameter int WORD_MAX = audio_serial_pkg::MAX_BITS
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire audio_serial_pkg::format_t formatSel,
    input wire audio_serial_pkg::width_t widthSel,
    input wire logic [WORD_MAX-1:0] leftIn,
    input wire logic [WORD_MAX-1:0] rightIn,
    output logic takeSample,
    audio_serial_if.source link
);

    // ==========================================================
    // Bit-clock divider
    logic [3:0] divCount;
    logic bitClk;
    logic frameSync;
    logic serialData;
    logic [5:0] slotPos;
    logic [WORD_MAX-1:0] curLeft;
    logic [WORD_MAX-1:0] curRight;

    wire divWrap = divCount == 4'(audio_serial_pkg::HALF_DIV - 1);
    // Data changes on the falling edge, stable at the rising one
    wire fallNow = divWrap && bitClk;

    // Frame position 0..63; sync toggles every 32
    wire [4:0] inSlot = slotPos[4:0];
    wire secondHalf = slotPos[5];
    wire [5:0] delay = audio_serial_pkg::msb_delay(formatSel, widthSel);
    wire [4:0] bits = audio_serial_pkg::word_bits(widthSel);
    wire [5:0] rel = {1'b0, inSlot} - delay;
    wire inBits = ({1'b0, inSlot} >= delay) && (rel < {1'b0, bits});
    wire [WORD_MAX-1:0] word = secondHalf ? curRight : curLeft;
    wire [5:0] bitIdx = {1'b0, bits} - 6'h01 - rel;
    wire nextData = inBits & word[bitIdx[4:0]];
    wire leftLvl = audio_serial_pkg::left_level(formatSel);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            divCount <= 4'h0;
            bitClk <= 1'b0;
            slotPos <= 6'h00;
            frameSync <= 1'b0;
            serialData <= 1'b0;
            curLeft <= '0;
            curRight <= '0;
            takeSample <= 1'b0;
        end else begin
            divCount <= divWrap ? 4'h0 : divCount + 4'h1;
            takeSample <= 1'b0;
            if (divWrap) begin
                bitClk <= ~bitClk;
            end
            if (fallNow) begin
                slotPos <= slotPos + 6'h01;
                frameSync <= secondHalf ? ~leftLvl : leftLvl;
                serialData <= nextData;
                if (slotPos == 6'h3F) begin
                    curLeft <= leftIn;
                    curRight <= rightIn;
                    takeSample <= 1'b1;
                end
            end
        end
    end

    assign link.bitClk = bitClk;
    assign link.frameSync = frameSync;
    assign link.serialData = serialData;

endmodule

// file: spdif_tx_serial_input_chk.sv
// Concurrent checks on the serial audio link and the receiving end.
// Instantiated by the bench beside the link; all in the sys_clk domain.
`timescale 1ns/1ps
module spdif_tx_serial_input_chk #(
    parameter int WORD_MAX = audio_serial_pkg::MAX_BITS
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic bitClk,
    input wire logic frameSync,
    input wire logic serialData,
    input wire audio_serial_pkg::format_t formatSel,
    input wire logic sampleValid,
    input wire logic [WORD_MAX-1:0] leftSample,
    input wire logic [WORD_MAX-1:0] rightSample
);
    // ==========================================================
    // Slot timing helpers
    localparam int SLOT_LAST = 2 * audio_serial_pkg::SLOT_BITS
        * audio_serial_pkg::HALF_DIV - 1;
    logic [7:0] syncAge;
    logic seenEdge;
    logic lastSync;
    wire syncEdge = (frameSync != lastSync);
    wire leftLevel = (formatSel != audio_serial_pkg::FMT_I2S);

    // First edge after reset may close a partial slot, so it is skipped
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            syncAge <= 8'h00;
            seenEdge <= 1'b0;
            lastSync <= 1'b0;
        end else begin
            lastSync <= frameSync;
            syncAge <= syncEdge ? 8'h00 : syncAge + 8'h01;
            seenEdge <= seenEdge | syncEdge;
        end
    end

    // ==========================================================
    // Properties
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Divider of one: each bit-clock phase lasts one system clock
    clk_rise_a: assert property ($rose(bitClk) |=> $fell(bitClk))
        else $error("bit clock high phase too long");
    clk_fall_a: assert property ($fell(bitClk) |=> $rose(bitClk))
        else $error("bit clock low phase too long");
    sync_launch_a: assert property ($changed(frameSync) && $past(rst_n)
        |-> $fell(bitClk)) else $error("frame sync moved off falling edge");
    data_launch_a: assert property ($changed(serialData) && $past(rst_n)
        |-> $fell(bitClk)) else $error("data moved off falling edge");
    slot_length_a: assert property (syncEdge && seenEdge
        |-> syncAge == SLOT_LAST) else $error("slot length wrong");
    valid_pulse_a: assert property (sampleValid |=> !sampleValid)
        else $error("sample valid longer than one cycle");
    valid_timing_a: assert property (sampleValid
        |-> syncAge inside {[2:4]} && frameSync == leftLevel)
        else $error("pair not handed over after right slot");
    hold_pair_a: assert property (!sampleValid && $past(rst_n)
        |-> $stable(leftSample) && $stable(rightSample))
        else $error("samples changed without valid");
endmodule

// file: spdif_tx_serial_input_bench.sv
// Bench: a source and a transmitter input joined by the serial link.
// Runs each format and width; checks the wire and the received pairs.
`timescale 1ns/1ps
module spdif_tx_serial_input_bench;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    audio_serial_pkg::format_t formatSel = audio_serial_pkg::FMT_I2S;
    audio_serial_pkg::width_t widthSel = audio_serial_pkg::WIDTH_24;
    logic [23:0] leftWord = 24'h000000;
    logic [23:0] rightWord = 24'h000000;
    logic [23:0] leftSample;
    logic [23:0] rightSample;
    logic sampleValid;
    audio_serial_pkg::format_t activeFormat;
    logic [31:0] slot;
    logic lastSync;
    logic leftLvl;
    logic checking = 1'b0;
    int pos, slots, nBits, dly;
    int mismatches = 0;
    int n_tests = 0;
    int bitsTab[4] = '{16, 18, 20, 24};
    int rjTab[4] = '{16, 14, 12, 8};

    audio_serial_if link();
    audio_serial_source #(.WORD_MAX(24)) audio_serial_source_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .formatSel(formatSel),
        .widthSel(widthSel), .leftIn(leftWord), .rightIn(rightWord),
        .takeSample(), .link(link));
    spdif_tx_serial_input #(.WORD_MAX(24)) spdif_tx_serial_input_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .formatSel(formatSel),
        .widthSel(widthSel), .link(link), .leftSample(leftSample),
        .rightSample(rightSample), .sampleValid(sampleValid),
        .activeFormat(activeFormat));
    spdif_tx_serial_input_chk #(.WORD_MAX(24)) spdif_tx_serial_input_chk_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .bitClk(link.bitClk),
        .frameSync(link.frameSync), .serialData(link.serialData),
        .formatSel(formatSel), .sampleValid(sampleValid),
        .leftSample(leftSample), .rightSample(rightSample));

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    // ==========================================================
    // Compare and closing report
    task automatic compare(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Wire monitor: one slot runs from one sync edge to the next
    task automatic check_slot();
        logic [31:0] mask;
        logic [31:0] exp;
        mask = ((32'h1 << nBits) - 32'h1) << (32 - dly - nBits);
        exp = {8'h00, (lastSync === leftLvl) ? leftWord : rightWord};
        exp = exp << (32 - dly - nBits);
        compare("slotLength", 32'h20, 32'(pos));
        compare("wireWord", exp & mask, slot & mask);
    endtask

    always @(posedge link.bitClk or negedge rst_n) begin
        if (!rst_n) begin
            slots = 0;
            pos = 0;
            lastSync = 1'b0;
        end else begin
            // Slots of the first frame carry the source's reset words
            if (link.frameSync !== lastSync) begin
                if (checking && slots > 2) begin
                    check_slot();
                end
                slots++;
                pos = 0;
                slot = 32'h00000000;
            end
            if (pos < 32) begin
                slot[31 - pos] = link.serialData;
            end
            pos++;
            lastSync = link.frameSync;
        end
    end

    // ==========================================================
    // One format and width, entered under a fresh reset
    task automatic run_case(input int f, input int w);
        int i;
        logic [23:0] m;
        @(negedge sys_clk);
        checking = 1'b0;
        rst_n = 1'b0;
        formatSel = audio_serial_pkg::format_t'(f);
        widthSel = audio_serial_pkg::width_t'(w);
        leftWord = 24'hC35A96 + 24'(4 * f + w);
        rightWord = 24'h3CA569 - 24'(4 * f + w);
        nBits = bitsTab[w];
        dly = (f == 0) ? 0 : (f == 1) ? 1 : rjTab[w];
        leftLvl = (f != 1);
        m = 24'((32'h1 << nBits) - 32'h1);
        repeat (3) @(negedge sys_clk);
        compare("resetFormat", 32'(audio_serial_pkg::FMT_I2S), 32'(activeFormat));
        compare("resetValid", 32'h0, 32'(sampleValid));
        rst_n = 1'b1;
        checking = 1'b1;
        // First pair may come from a partial slot, so the third is judged
        repeat (3) begin
            i = 0;
            do begin
                @(posedge sys_clk);
                #1;
                i++;
            end while (sampleValid !== 1'b1 && i < 400);
            if (i >= 400) begin
                mismatches++;
                $display("Error sampleValid expected 1 seen timeout");
                conclude();
            end
        end
        compare("leftSample", 32'(leftWord & m), 32'(leftSample));
        compare("rightSample", 32'(rightWord & m), 32'(rightSample));
        compare("activeFormat", 32'(f), 32'(activeFormat));
        $display("Test format %0d width %0d done", f, nBits);
    endtask

    initial begin
        repeat (12) @(negedge sys_clk);
        compare("activeFormat", 32'(audio_serial_pkg::FMT_I2S), 32'(activeFormat));
        for (int f = 0; f < 3; f++) begin
            for (int w = 0; w < 4; w++) begin
                run_case(f, w);
            end
        end
        conclude();
    end
endmodule
